/* File: scpm_consts.vh */
// constants of the three-wire control port: addresses, fields, reset values
`ifndef SCPM_CONSTS_VH
`define SCPM_CONSTS_VH

`define SCPM_REG_W 24
`define SCPM_NUM_REGS 10
`define SCPM_CFG_REGS 9
`define SCPM_HDR_BITS 3'h5
`define SCPM_ADDR_FIRST 4'h1
`define SCPM_ADDR_LAST 4'hA
`define SCPM_ADDR_STAT 4'hA
`define SCPM_ADDR_MODEM 4'hB
`define SCPM_ADDR_PWR 4'h5
`define SCPM_ADDR_CLK 4'h4
`define SCPM_MIN_WBITS 5'h04
`define SCPM_FULL_WBITS 5'h18
`define SCPM_RD_BITS_HI 23
`define SCPM_RD_BITS_LO 21
`define SCPM_MODEM_BIT 20
`define SCPM_TXDIV_HI 23
`define SCPM_TXDIV_LO 18
`define SCPM_TXDIV_HALF 9'h008

`define SCPM_RST_R1 24'h003240
`define SCPM_RST_R2 24'h003240
`define SCPM_RST_R3 24'h6F8064
`define SCPM_RST_R4 24'h820800
`define SCPM_RST_R5 24'h000000
`define SCPM_RST_R6 24'h000000
`define SCPM_RST_R7 24'h000000
`define SCPM_RST_R8 24'h000000
`define SCPM_RST_R9 24'h000000

`endif

/* File: scpm_serial_port.v */
// three-wire serial control port with register file and data-modem hand-over
// What this block and its host do
// [RULE_01] port always alive, ignores power-down bits
// [RULE_02] host keeps enable low between transfers
// [RULE_03] ten 24-bit registers, addresses 1 to 10
// [RULE_04] reg10 and reg5 top bits are status
// [RULE_05] all bits move on serial clock rise
// [RULE_06] write header: 0 then four address bits
// [RULE_07] enable fall after header latches address
// [RULE_08] data shifted MSB first, unused bits zero
// [RULE_09] enable pulse fall commits written data
// [RULE_10] short writes update low bits, minimum four
// [RULE_11] read header: 1 then four address bits
// [RULE_12] read header fall loads shifter, pin input
// [RULE_13] first read edge drives MSB, 24 edges
// [RULE_14] one to three edges read reg5 top bits
// [RULE_15] enable pulse fall ends read, pin input
// [RULE_16] modem tx clock is crystal/(16*counter) on status
// [RULE_17] modem bit set last, then address 11
// [RULE_18] address 11 with modem bit drives recovered clock
// [RULE_19] host releases data pin before that fall
// [RULE_20] port ignores traffic while recovered clock driven
// [RULE_21] enable pulse fall leaves modem hand-over
// [RULE_22] host keeps modem bit clear otherwise
// [RULE_23] invalid addresses change nothing, except 11
`timescale 1ns/1ps
`default_nettype none
`include "scpm_consts.vh"

module scpm_serial_port (
	input wire clk,
	input wire rst_b,
	input wire serClk,
	input wire serEn,
	input wire serDataIn,
	output reg serDataOut,
	output reg serDataOe_b,
	input wire [2:0] statusIn,
	input wire [23:0] statusRegIn,
	input wire recoveredClk,
	input wire xtalTick,
	input wire statusLineIn,
	output reg statusPinOut,
	output reg [215:0] cfgRegs
);

	localparam ST_IDLE = 3'h0;
	localparam ST_HDR = 3'h1;
	localparam ST_WDATA = 3'h2;
	localparam ST_WEND = 3'h3;
	localparam ST_RDATA = 3'h4;
	localparam ST_REND = 3'h5;
	localparam ST_MODEM = 3'h6;
	localparam ST_MEND = 3'h7;

	reg [2:0] state_reg;
	reg serClkPrev_reg;
	reg serEnPrev_reg;
	reg [4:0] hdr_reg;
	reg [2:0] hdrCnt_reg;
	reg [23:0] shift_reg;
	reg [4:0] bitCnt_reg;
	reg [3:0] addr_reg;
	reg addrOk_reg;
	reg [8:0] divCnt_reg;
	reg txClk_reg;

	wire clkRise = serClk & ~serClkPrev_reg;
	wire enRise = serEn & ~serEnPrev_reg;
	wire enFall = ~serEn & serEnPrev_reg;
	wire hdrRead = hdr_reg[4];
	wire [3:0] hdrAddr = hdr_reg[3:0];
	wire modemOn = cfgRegs[(`SCPM_ADDR_PWR - 1) * `SCPM_REG_W + `SCPM_MODEM_BIT];
	wire [5:0] txDiv = cfgRegs[(`SCPM_ADDR_CLK - 1) * `SCPM_REG_W + `SCPM_TXDIV_HI -:
		6];

	// valid register address, 1..10
	function addrValid;
		input [3:0] a;
		begin
			addrValid = (a >= `SCPM_ADDR_FIRST) && (a <= `SCPM_ADDR_LAST); // RULE_03
		end
	endfunction

	// readback view of a register, status fields overlaid
	function [23:0] readReg;
		input [3:0] a;
		reg [23:0] v;
		begin
			v = 24'h000000;
			if (a == `SCPM_ADDR_STAT) begin
				v = statusRegIn; // RULE_04
			end else if (addrValid(a)) begin
				v = cfgRegs[(a - 4'h1) * `SCPM_REG_W +: `SCPM_REG_W];
				if (a == `SCPM_ADDR_PWR) begin
					v[`SCPM_RD_BITS_HI:`SCPM_RD_BITS_LO] = statusIn; // RULE_04
				end
			end
			readReg = v;
		end
	endfunction

	// lower-bit mask covering the bits that were shifted in
	function [23:0] lowMask;
		input [4:0] n;
		begin
			if (n >= `SCPM_FULL_WBITS) begin
				lowMask = 24'hFFFFFF;
			end else begin
				lowMask = ~(24'hFFFFFF << n); // RULE_10
			end
		end
	endfunction

	wire [23:0] commitMask = lowMask(bitCnt_reg);
	wire [23:0] oldVal = cfgRegs[(addr_reg - 4'h1) * `SCPM_REG_W +: `SCPM_REG_W];
	wire [23:0] newVal = (oldVal & ~commitMask) | (shift_reg & commitMask);

	// port sequencer; no power-down bit reaches it
	always @(posedge clk or negedge rst_b) begin // RULE_01
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			serClkPrev_reg <= 1'b0;
			serEnPrev_reg <= 1'b0;
			hdr_reg <= 5'h00;
			hdrCnt_reg <= 3'h0;
			shift_reg <= 24'h000000;
			bitCnt_reg <= 5'h00;
			addr_reg <= 4'h0;
			addrOk_reg <= 1'b0;
			serDataOut <= 1'b0;
			serDataOe_b <= 1'b1;
			cfgRegs <= {`SCPM_RST_R9, `SCPM_RST_R8, `SCPM_RST_R7, `SCPM_RST_R6,
				`SCPM_RST_R5, `SCPM_RST_R4, `SCPM_RST_R3, `SCPM_RST_R2, `SCPM_RST_R1};
		end else begin
			serClkPrev_reg <= serClk;
			serEnPrev_reg <= serEn;
			case (state_reg)
				ST_IDLE: begin
					if (enRise) begin
						state_reg <= ST_HDR;
						hdrCnt_reg <= 3'h0;
					end
				end
				ST_HDR: begin
					if (clkRise && hdrCnt_reg != `SCPM_HDR_BITS) begin
						hdr_reg <= {hdr_reg[3:0], serDataIn}; // RULE_06 RULE_11 RULE_05
						hdrCnt_reg <= hdrCnt_reg + 3'h1;
					end
					if (enFall) begin
						addr_reg <= hdrAddr; // RULE_07
						bitCnt_reg <= 5'h00;
						if (hdrCnt_reg != `SCPM_HDR_BITS) begin
							state_reg <= ST_IDLE;
						end else if (hdrAddr == `SCPM_ADDR_MODEM && modemOn) begin
							state_reg <= ST_MODEM; // RULE_18 RULE_23
						end else if (hdrRead) begin
							shift_reg <= readReg(hdrAddr); // RULE_12
							state_reg <= ST_RDATA;
						end else begin
							addrOk_reg <= addrValid(hdrAddr) && hdrAddr != `SCPM_ADDR_STAT; // RULE_23
							state_reg <= ST_WDATA;
						end
					end
				end
				ST_WDATA: begin
					if (clkRise) begin
						shift_reg <= {shift_reg[22:0], serDataIn}; // RULE_08 RULE_05
						if (bitCnt_reg != `SCPM_FULL_WBITS) begin
							bitCnt_reg <= bitCnt_reg + 5'h01;
						end
					end
					if (enRise) begin
						state_reg <= ST_WEND;
					end
				end
				ST_WEND: begin
					if (enFall) begin
						if (addrOk_reg && bitCnt_reg >= `SCPM_MIN_WBITS) begin
							cfgRegs[(addr_reg - 4'h1) * `SCPM_REG_W +: `SCPM_REG_W] <= newVal; // RULE_09 RULE_10
						end
						state_reg <= ST_IDLE;
					end
				end
				ST_RDATA: begin
					if (clkRise) begin
						serDataOe_b <= 1'b0; // RULE_13
						serDataOut <= shift_reg[23]; // RULE_13 RULE_14 RULE_05
						shift_reg <= {shift_reg[22:0], 1'b0};
					end
					if (enRise) begin
						state_reg <= ST_REND;
					end
				end
				ST_REND: begin
					if (enFall) begin
						serDataOe_b <= 1'b1; // RULE_15
						state_reg <= ST_IDLE;
					end
				end
				ST_MODEM: begin
					serDataOe_b <= 1'b0; // RULE_18
					serDataOut <= recoveredClk; // RULE_18
					if (enRise) begin
						state_reg <= ST_MEND; // RULE_20
					end
				end
				ST_MEND: begin
					serDataOut <= recoveredClk;
					if (enFall) begin
						serDataOe_b <= 1'b1; // RULE_21
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// transmit data clock: toggles every 8*counter crystal ticks
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divCnt_reg <= 9'h000;
			txClk_reg <= 1'b0;
			statusPinOut <= 1'b0;
		end else begin
			if (!modemOn || txDiv == 6'h00) begin
				divCnt_reg <= 9'h000;
				txClk_reg <= 1'b0;
			end else if (xtalTick) begin
				if (divCnt_reg >= ({3'h0, txDiv} * `SCPM_TXDIV_HALF) - 9'h001) begin
					divCnt_reg <= 9'h000;
					txClk_reg <= ~txClk_reg; // RULE_16
				end else begin
					divCnt_reg <= divCnt_reg + 9'h001;
				end
			end
			statusPinOut <= modemOn ? txClk_reg : statusLineIn; // RULE_16
		end
	end

endmodule // scpm_serial_port

`default_nettype wire

/* File: scpm_serial_port_asserts.sv */
// assertion checker for the three-wire control port
`timescale 1ns/1ps
`default_nettype none
`include "scpm_consts.vh"
module scpm_serial_port_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic serClk,
	input wire logic serEn,
	input wire logic serDataOut,
	input wire logic serDataOe_b,
	input wire logic recoveredClk,
	input wire logic statusLineIn,
	input wire logic statusPinOut,
	input wire logic [215:0] cfgRegs
);
	wire modemBit = cfgRegs[116];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_reset_defaults: assert property (
		$rose(rst_b) |-> serDataOe_b && cfgRegs[95:72] == `SCPM_RST_R4
	) else $error("reset values wrong");
	chk_header_quiet: assert property (
		(serEn && serDataOe_b) |=> serDataOe_b
	) else $error("pin driven during header");
	chk_drive_start: assert property (
		$fell(serDataOe_b) |-> !serEn && (modemBit || $past(serClk) || $past(serClk, 2))
	) else $error("pin driven without cause");
	chk_bit_on_rise: assert property (
		(!serDataOe_b && !modemBit && $changed(serDataOut)) |-> ($past(serClk) || $past(serClk, 2))
	) else $error("read bit moved without clock rise");
	chk_pin_release: assert property (
		($fell(serEn) && !serDataOe_b) |-> ##[1:2] serDataOe_b
	) else $error("pin not released by end pulse");
	chk_commit_edge: assert property (
		$changed(cfgRegs) |-> !serEn && ($past(serEn, 2) || $past(serEn, 3))
	) else $error("registers changed outside commit");
	chk_status_pass: assert property (
		(!modemBit && !$past(modemBit) && $past(rst_b)) |-> statusPinOut == $past(statusLineIn)
	) else $error("status line not passed through");
	chk_modem_follow: assert property (
		(!serDataOe_b && modemBit && !serEn && !$past(serEn, 2) && !$past(serDataOe_b, 3))
		|-> (serDataOut == $past(recoveredClk) || serDataOut == $past(recoveredClk, 2))
	) else $error("recovered clock not forwarded");
endmodule // scpm_serial_port_asserts
`default_nettype wire

/* File: scpm_host_model.sv */
// host side model driving serial clock, enable and data
`timescale 1ns/1ps
`default_nettype none
module scpm_host_model (
	input wire logic clk,
	input wire logic pin,
	output logic serClk,
	output logic serEn,
	output logic hostOe,
	output logic hostD
);
	initial begin
		serClk = 1'b0;
		serEn = 1'b0;
		hostOe = 1'b1;
		hostD = 1'b0;
	end
	task automatic step();
		repeat (2) @(negedge clk);
	endtask
	task automatic bitClk(input logic b);
		hostD = b;
		step();
		serClk = 1'b1;
		step();
		serClk = 1'b0;
		step();
	endtask
	task automatic pulse();
		serEn = 1'b1;
		step();
		serEn = 1'b0;
		step();
		step();
	endtask
	task automatic xfer(input logic rd, input logic [3:0] a, input logic [23:0] d, input int n,
		output logic [23:0] q);
		q = 24'h000000;
		hostOe = 1'b1;
		serEn = 1'b1;
		step();
		bitClk(rd);
		for (int i = 3; i >= 0; i--) bitClk(a[i]);
		if (rd || a == 4'hB) hostOe = 1'b0;
		serEn = 1'b0;
		step();
		if (a == 4'hB) return;
		for (int i = n - 1; i >= 0; i--) begin
			if (rd) begin
				serClk = 1'b1;
				step();
				q = {q[22:0], pin};
				serClk = 1'b0;
				step();
			end else bitClk(d[i]);
		end
		pulse();
	endtask
endmodule // scpm_host_model
`default_nettype wire

/* File: scpm_serial_port_test.sv */
// self-checking testbench of the control port
`timescale 1ns/1ps
`default_nettype none
`include "scpm_consts.vh"
module scpm_serial_port_test;
	logic clk, rst_b;
	logic [7:0] cyc = 8'h00;
	logic [2:0] statIn = 3'h5;
	logic [23:0] stat10 = 24'hC3A51E;
	logic [23:0] q;
	logic [215:0] snap;
	wire logic serClk, serEn, hostOe, hostD, serDataOut, serDataOe_b, statusPinOut;
	wire logic [215:0] cfgRegs;
	wire logic pin = !serDataOe_b ? serDataOut : hostOe ? hostD : cyc[0];
	int mismatches, comparisons;
	time t0;
	scpm_host_model host (.clk(clk), .pin(pin), .serClk(serClk), .serEn(serEn), .hostOe(hostOe),
		.hostD(hostD));
	scpm_serial_port DUT (.clk(clk), .rst_b(rst_b), .serClk(serClk), .serEn(serEn),
		.serDataIn(pin), .serDataOut(serDataOut), .serDataOe_b(serDataOe_b), .statusIn(statIn),
		.statusRegIn(stat10), .recoveredClk(cyc[2]), .xtalTick(cyc[0]), .statusLineIn(cyc[3]),
		.statusPinOut(statusPinOut), .cfgRegs(cfgRegs));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(negedge clk) cyc <= cyc + 8'h01;
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic t_rw();
		check("reg1 default", `SCPM_RST_R1, cfgRegs[23:0]);
		host.xfer(1'b0, 4'h6, 24'h5A3C96, 24, q);
		check("reg6 write", 24'h5A3C96, cfgRegs[143:120]);
		host.xfer(1'b0, 4'h6, 24'h00000A, 4, q);
		check("reg6 short write", 24'h5A3C9A, cfgRegs[143:120]);
		host.xfer(1'b0, 4'h6, 24'h000000, 3, q);
		snap = cfgRegs;
		host.xfer(1'b0, 4'h0, 24'hFFFFFF, 24, q);
		host.xfer(1'b0, 4'hF, 24'hFFFFFF, 24, q);
		host.xfer(1'b0, 4'hA, 24'hFFFFFF, 24, q);
		host.xfer(1'b0, 4'hB, 24'h000000, 0, q);
		check("addr 11 without modem bit", 24'h000001, {23'h0, serDataOe_b});
		host.pulse();
		check("invalid writes", 24'h000000, {23'h0, cfgRegs !== snap});
		host.xfer(1'b1, 4'h6, 24'h0, 24, q);
		check("reg6 read", 24'h5A3C9A, q);
	endtask
	task automatic t_status();
		host.xfer(1'b0, 4'h5, 24'h0007FF, 24, q);
		check("reg5 power bits", 24'h0007FF, cfgRegs[119:96]);
		host.xfer(1'b1, 4'h5, 24'h0, 3, q);
		check("reg5 status", {21'h0, statIn}, q);
		host.xfer(1'b1, 4'hA, 24'h0, 24, q);
		check("reg10 read", stat10, q);
	endtask
	task automatic t_modem();
		host.xfer(1'b0, 4'h5, 24'h100000, 24, q);
		@(posedge statusPinOut);
		t0 = $time;
		@(negedge statusPinOut);
		check("tx clock half period", 24'h000800, 24'($time - t0));
		host.xfer(1'b0, 4'hB, 24'h0, 0, q);
		repeat (16) @(negedge clk);
		check("modem pin driven", 24'h0, {23'h0, serDataOe_b});
		host.bitClk(1'b1);
		check("traffic ignored", 24'h0, {23'h0, serDataOe_b});
		host.pulse();
		check("modem pin released", 24'h1, {23'h0, serDataOe_b});
		host.xfer(1'b0, 4'h5, 24'h000000, 24, q);
		check("modem bit cleared", 24'h0, cfgRegs[119:96]);
	endtask
	initial begin
		#200000;
		mismatches++;
		end_sim();
	end
	initial begin
		rst_b = 1'b0;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		t_rw();
		t_status();
		t_modem();
		end_sim();
	end
endmodule // scpm_serial_port_test
bind scpm_serial_port scpm_serial_port_asserts chkr (.clk(clk), .rst_b(rst_b), .serClk(serClk),
	.serEn(serEn), .serDataOut(serDataOut), .serDataOe_b(serDataOe_b),
	.recoveredClk(recoveredClk), .statusLineIn(statusLineIn), .statusPinOut(statusPinOut),
	.cfgRegs(cfgRegs));
`default_nettype wire
